// ===== rtl/asrs_pkg.sv
// Constants and types shared by the converter setup and readout sequencer.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package asrs_pkg;

    // ********************************************************
    // Clock and serial timing
    // ********************************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SCLK_HALF_NS   = 400;  // Least half period of the serial clock
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_LAST      = 17;   // Setup half, 16 clock halves, release half

    // ********************************************************
    // Register offsets (byte addresses)
    // ********************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CFG     = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_RESULT  = 8'h10;
    localparam logic [7:0] OFS_INTSTAT = 8'h14;
    localparam logic [7:0] OFS_INTMASK = 8'h18;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int          CTRL_START_BIT  = 0;
    localparam int          INT_SAMPLE_BIT  = 0;
    localparam int          INT_DONE_BIT    = 1;
    localparam logic [7:0]  FILT_HIGH_RST   = 8'h4f;  // 24-bit, bipolar, boost off, top nibble set
    localparam logic [7:0]  FILT_LOW_RST    = 8'ha0;  // Largest allowed low part
    localparam logic [7:0]  MODE_RST        = 8'h20;  // Gain 1, burnout off, no sync, self-cal
    localparam logic [15:0] COUNT_RST       = 16'h03e8; // 1000 samples
    localparam logic [1:0]  INTMASK_RST     = 2'h0;

    // ********************************************************
    // Command bytes for the communications register
    // ********************************************************
    localparam logic [7:0] CMD_CHAN_FHIGH = 8'h27;  // Channel six pair, next: filter high
    localparam logic [7:0] CMD_FLOW       = 8'h37;  // Next: filter low
    localparam logic [7:0] CMD_MODE       = 8'h17;  // Next: mode register
    localparam logic [7:0] CMD_READ_DATA  = 8'h5f;  // Next: 24-bit data read
    localparam logic [7:0] READ_FILL      = 8'h00;  // Driven while reading
    localparam logic [2:0] SETUP_LAST     = 3'h5;
    localparam logic [2:0] READ_LAST      = 3'h2;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] filtLow;
        logic [7:0] filtHigh;
    } asrs_cfg_s;

    typedef struct packed {
        logic [15:0] taken;
        logic [13:0] zero;
        logic        done;
        logic        busy;
    } asrs_status_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_WAIT  = 3'b011,
        ST_RDCMD = 3'b010,
        ST_READ  = 3'b110,
        ST_STORE = 3'b111,
        ST_DONE  = 3'b101
    } asrs_state_e;

endpackage : asrs_pkg

// ===== rtl/asrs_sequencer.sv
// Host controller that sets up a sigma-delta converter over its three-wire
// serial port and then reads a programmed number of 24-bit results.
// Assumes the converter's clock idle select is strapped by this block (high),
// and that software reaches the controller over AXI4-Lite on mclk.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Setup opens with a communications write that picks the channel and names the next register.
// - Command byte 0x27 picks the sixth input pair and points the next write at filter high.
// - Filter high carries the top four filter bits plus word length, polarity and boost, 0x4f by default.
// - Command byte 0x37 points the next write at filter low.
// - Filter low carries the bottom eight filter bits.
// - Filter low defaults to 0xa0, the largest allowed low part.
// - Command byte 0x17 points the next write at the mode register.
// - Mode byte 0x20 sets gain one, burnout off, no sync, and starts a self-calibration.
// - The converter pulls its ready line low when a fresh word waits, and the host polls it before each read.
// - Every result read is preceded by command byte 0x5f for a 24-bit data read.
// - A result arrives as three successive byte transfers.
// - Wait and read repeat until the programmed sample count is reached.
// - Bits travel most significant first in both directions.
module asrs_sequencer
    import asrs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AXI4-Lite write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // AXI4-Lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Interrupt
    output logic             irq,
    // Converter pins
    output logic             sclk,
    output logic             csN,
    output logic             devDataIn,
    input  wire logic        devDataOut,
    input  wire logic        resultReadyN,
    output logic             clockIdlePolaritySelect
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic        rdyMeta;
    logic        rdySync;
    logic        misoMeta;
    logic        misoSync;

    // Two stages each; only the second stage is read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdyMeta  <= 1'b1;
            rdySync  <= 1'b1;
            misoMeta <= 1'b0;
            misoSync <= 1'b0;
        end else begin
            rdyMeta  <= resultReadyN;
            rdySync  <= rdyMeta;
            misoMeta <= devDataOut;
            misoSync <= misoMeta;
        end
    end

    // Clock idles high, so the converter's select strap is tied high
    assign clockIdlePolaritySelect = 1'b1;

    // ********************************************************
    // Register state
    // ********************************************************
    asrs_cfg_s    cfg;
    logic [15:0]  sampleCount;
    logic [23:0]  result;
    logic [1:0]   intStatus;
    logic [1:0]   intMask;
    logic [15:0]  taken;
    logic         doneFlag;
    asrs_state_e  state;

    // ********************************************************
    // AXI4-Lite write path
    // ********************************************************
    logic        awHeld;
    logic [7:0]  awAddrQ;
    logic        wHeld;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;

    wire         awTake   = awvalid && awready;
    wire         wTake    = wvalid && wready;
    wire         doWrite  = awHeld && wHeld && !bvalid;
    wire [31:0]  wMask    = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
    wire         selCtrl  = awAddrQ == OFS_CTRL;
    wire         selCfg   = awAddrQ == OFS_CFG;
    wire         selCount = awAddrQ == OFS_COUNT;
    wire         selStat  = awAddrQ == OFS_STATUS;
    wire         selRes   = awAddrQ == OFS_RESULT;
    wire         selIntSt = awAddrQ == OFS_INTSTAT;
    wire         selMask  = awAddrQ == OFS_INTMASK;
    wire         wrMapped = selCtrl || selCfg || selCount || selStat || selRes || selIntSt || selMask;
    wire [31:0]  cfgMerged   = ({8'h00, cfg} & ~wMask) | (wDataQ & wMask);
    wire [31:0]  countMerged = ({16'h0000, sampleCount} & ~wMask) | (wDataQ & wMask);
    wire [31:0]  maskMerged  = ({30'h0, intMask} & ~wMask) | (wDataQ & wMask);
    wire         startReq    = doWrite && selCtrl && wStrbQ[0] && wDataQ[CTRL_START_BIT];

    assign awready = !awHeld;
    assign wready  = !wHeld;

    // Address and data are latched independently, either may come first
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld  <= 1'b0;
            awAddrQ <= 8'h00;
            wHeld   <= 1'b0;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
        end else begin
            if (awTake) begin
                awHeld  <= 1'b1;
                awAddrQ <= awaddr;
            end else if (doWrite) begin
                awHeld  <= 1'b0;
            end
            if (wTake) begin
                wHeld  <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end else if (doWrite) begin
                wHeld  <= 1'b0;
            end
        end
    end

    // Response one cycle after both halves are held; unmapped gives SLVERR
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= 2'b00;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= wrMapped ? 2'b00 : 2'b10;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Software-written configuration; read-only offsets ignore writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg         <= '{mode: MODE_RST, filtLow: FILT_LOW_RST, filtHigh: FILT_HIGH_RST};
            sampleCount <= COUNT_RST;
            intMask     <= INTMASK_RST;
        end else if (doWrite) begin
            if (selCfg) cfg <= asrs_cfg_s'(cfgMerged[23:0]);
            if (selCount) sampleCount <= countMerged[15:0];
            if (selMask) intMask <= maskMerged[1:0];
        end
    end

    // ********************************************************
    // AXI4-Lite read path
    // ********************************************************
    asrs_status_s statusWord;
    logic [31:0]  readMux;
    logic         rdMapped;

    wire          arTake = arvalid && arready;
    wire          rdIntSt = arTake && (araddr == OFS_INTSTAT);

    assign arready    = !rvalid;
    assign statusWord = '{taken: taken, zero: 14'h0000, done: doneFlag, busy: state != ST_IDLE};

    // Read selection by address
    always_comb begin
        readMux  = 32'h0000_0000;
        rdMapped = 1'b1;
        case (araddr)
            OFS_CTRL:    readMux = 32'h0000_0000;
            OFS_CFG:     readMux = {8'h00, cfg};
            OFS_COUNT:   readMux = {16'h0000, sampleCount};
            OFS_STATUS:  readMux = statusWord;
            OFS_RESULT:  readMux = {8'h00, result};
            OFS_INTSTAT: readMux = {30'h0, intStatus};
            OFS_INTMASK: readMux = {30'h0, intMask};
            default:     rdMapped = 1'b0;
        endcase
    end

    // Answer one cycle after the address is taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= 2'b00;
        end else if (arTake) begin
            rvalid <= 1'b1;
            rdata  <= readMux;
            rresp  <= rdMapped ? 2'b00 : 2'b10;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ********************************************************
    // Serial byte engine
    // ********************************************************
    logic        engActive;
    logic [4:0]  halfCnt;
    logic [2:0]  divCnt;
    logic [7:0]  txShift;
    logic [7:0]  rxShift;
    logic [7:0]  rxByte;
    logic        byteDone;
    logic        byteGo;
    logic [7:0]  txByte;

    wire         halfTick  = engActive && (divCnt == 3'(SCLK_HALF_CYC - 1));
    wire [4:0]   halfNext  = halfCnt + 5'h01;
    wire         lastHalf  = halfCnt == 5'(HALF_LAST);
    wire         capHalf   = !halfCnt[0] && (halfCnt != 5'h00) && (halfCnt != 5'(HALF_LAST));

    // Divider: one enable per half serial clock period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 3'h0;
        end else if (!engActive || halfTick) begin
            divCnt <= 3'h0;
        end else begin
            divCnt <= divCnt + 3'h1;
        end
    end

    // Mode 3 framing: drive on the falling edge, capture at end of high half
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            engActive <= 1'b0;
            halfCnt   <= 5'h00;
            sclk      <= 1'b1;
            csN       <= 1'b1;
            devDataIn <= 1'b0;
            txShift   <= 8'h00;
            rxShift   <= 8'h00;
            rxByte    <= 8'h00;
            byteDone  <= 1'b0;
        end else begin
            byteDone <= 1'b0;
            if (byteGo) begin
                engActive <= 1'b1;
                halfCnt   <= 5'h00;
                csN       <= 1'b0;
                txShift   <= txByte;
            end else if (halfTick) begin
                halfCnt <= halfNext;
                if (capHalf) rxShift <= {rxShift[6:0], misoSync};
                if (lastHalf) begin
                    engActive <= 1'b0;
                    byteDone  <= 1'b1;
                    rxByte    <= rxShift;
                end else if (halfNext == 5'(HALF_LAST)) begin
                    csN <= 1'b1;
                end else if (halfNext[0]) begin
                    sclk      <= 1'b0;
                    devDataIn <= txShift[7];
                    txShift   <= {txShift[6:0], 1'b0};
                end else begin
                    sclk <= 1'b1;
                end
            end
        end
    end

    // ********************************************************
    // Sequencer
    // ********************************************************
    asrs_state_e next_state;
    logic [2:0]  byteIdx;
    logic        pending;
    logic [23:0] sampleAcc;

    wire         needByte  = (state == ST_SETUP) || (state == ST_RDCMD) || (state == ST_READ);
    wire         lastTaken = (taken + 16'h0001) == sampleCount;

    // Setup byte list: command, payload pairs in fixed order
    function automatic logic [7:0] setupByte(input logic [2:0] idx, input asrs_cfg_s c);
        case (idx)
            3'h0:    setupByte = CMD_CHAN_FHIGH;
            3'h1:    setupByte = c.filtHigh;
            3'h2:    setupByte = CMD_FLOW;
            3'h3:    setupByte = c.filtLow;
            3'h4:    setupByte = CMD_MODE;
            default: setupByte = c.mode;
        endcase
    endfunction : setupByte

    // Back-to-back command and payload rely on the converter being ready at once
    assign byteGo = needByte && !pending && !engActive && !byteDone;
    assign txByte = (state == ST_SETUP) ? setupByte(byteIdx, cfg) :
                    (state == ST_RDCMD) ? CMD_READ_DATA : READ_FILL;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (startReq) next_state = ST_SETUP;
            ST_SETUP: if (byteDone && byteIdx == SETUP_LAST)
                          next_state = (sampleCount == 16'h0000) ? ST_DONE : ST_WAIT;
            ST_WAIT:  if (!rdySync) next_state = ST_RDCMD;
            ST_RDCMD: if (byteDone) next_state = ST_READ;
            ST_READ:  if (byteDone && byteIdx == READ_LAST) next_state = ST_STORE;
            ST_STORE: next_state = lastTaken ? ST_DONE : ST_WAIT;
            ST_DONE:  next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // State, byte index and request bookkeeping
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            byteIdx <= 3'h0;
            pending <= 1'b0;
        end else begin
            state <= next_state;
            if (byteGo) pending <= 1'b1;
            else if (byteDone) pending <= 1'b0;
            if (next_state != state) byteIdx <= 3'h0;
            else if (byteDone) byteIdx <= byteIdx + 3'h1;
        end
    end

    // Result assembly, first byte is the most significant
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sampleAcc <= 24'h000000;
            result    <= 24'h000000;
            taken     <= 16'h0000;
            doneFlag  <= 1'b0;
        end else begin
            if (state == ST_READ && byteDone) sampleAcc <= {sampleAcc[15:0], rxByte};
            if (state == ST_STORE) begin
                result <= sampleAcc;
                taken  <= taken + 16'h0001;
            end
            if (startReq && state == ST_IDLE) begin
                taken    <= 16'h0000;
                doneFlag <= 1'b0;
            end else if (state == ST_DONE) begin
                doneFlag <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Interrupts
    // ********************************************************
    wire [1:0] intSet = {state == ST_DONE, state == ST_STORE};

    // Sticky events, cleared by a read; a set in the same cycle wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intStatus <= 2'h0;
        end else begin
            intStatus <= (rdIntSt ? 2'h0 : intStatus) | intSet;
        end
    end

    assign irq = |(intStatus & intMask);

endmodule : asrs_sequencer

`default_nettype wire

// ===== sim/asrs_sequencer_props.sv
// Checker for the sequencer: serial framing and register-bus handshakes.
// Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module asrs_sequencer_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Bus and link
    input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [31:0] rdata,
    input wire logic        sclk, csN, devDataIn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ********************************************************
    // Frame counters
    // ********************************************************
    logic [6:0] lowCnt;
    logic [3:0] fallCnt;
    logic       sclkQ;
    // Counted here because a repetition of 68 would be too long to unroll
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= 7'h0;
            fallCnt <= 4'h0;
            sclkQ <= 1'b1;
        end else begin
            lowCnt <= csN ? 7'h0 : lowCnt + 7'h1;
            fallCnt <= csN ? 4'h0 : fallCnt + {3'h0, sclkQ & ~sclk};
            sclkQ <= sclk;
        end
    end
    a_cs_span: assert property ($rose(csN) |-> lowCnt == 7'd68) else $error("select low span wrong");
    a_clock_count: assert property ($rose(csN) |-> fallCnt == 4'd8) else $error("not eight clocks");
    a_idle_high: assert property (csN |-> sclk) else $error("clock not idle high");
    a_cs_gap: assert property ($rose(csN) |-> csN [*4]) else $error("select gap short");
    a_half_period: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk) else $error("half period wrong");
    a_bit_steady: assert property (!csN && !$past(csN) && $changed(devDataIn) |-> $fell(sclk))
        else $error("data moved off clock fall");
    a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("no write response");
    a_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data unstable");
    a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("no read data");
    c_frame: cover property ($rose(csN));
    c_read: cover property (rvalid && rready);
    c_write: cover property (bvalid && bready);
endmodule : asrs_sequencer_props
bind asrs_sequencer asrs_sequencer_props chk (.mclk(mclk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .sclk(sclk), .csN(csN), .devDataIn(devDataIn));
`default_nettype wire

// ===== sim/asrs_dev_model.sv
// Behavioural converter: serial slave, clock idles high, data MSB first.
// Assumes the host frames every byte with its select line.
`timescale 1ns/1ps
`default_nettype none
module asrs_dev_model #(
    parameter int READY_NS = 30000
) (
    // Serial pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic devDataIn,
    output var logic devDataOut,
    output var logic resultReadyN
);
    // ********************************************************
    // Byte engine
    // ********************************************************
    logic [7:0]  sh, cmd;
    logic [7:0]  got[$];
    logic [7:0]  regs[8];
    logic [23:0] word, sent;
    logic        wrNext;
    int          nb, rdLeft, k, early, dirty;
    initial begin
        devDataOut = 1'b0;
        resultReadyN = 1'b1;
        wrNext = 1'b0;
        {rdLeft, k, early, dirty} = '0;
    end
    // New word after a slow delay; ready falls when it lands
    task automatic settle;
        resultReadyN = 1'b1;
        fork
            #(READY_NS) resultReadyN = 1'b0;
        join_none
    endtask : settle
    task automatic endByte;
        if (rdLeft > 0) begin
            rdLeft--;
            if (rdLeft == 0) settle();
        end else begin
            got.push_back(sh);
            if (wrNext) begin
                wrNext = 1'b0;
                regs[cmd[6:4]] = sh;
                if (cmd == 8'h17) settle();
            end else begin
                cmd = sh;
                wrNext = !sh[3];
                if (sh[3]) begin
                    rdLeft = 3;
                    if (resultReadyN) early++;
                    k++;
                    word = {8'h9a, k[15:0]} ^ 24'h5c3e71;
                    sent = word;
                end
            end
        end
    endtask : endByte
    always @(negedge csN) nb = 0;
    // Input ignored while a read runs
    always @(posedge sclk) if (!csN) begin
        if (rdLeft == 0) sh = {sh[6:0], devDataIn};
        else if (devDataIn !== 1'b0) dirty++;
        nb++;
        if (nb == 8) endByte();
    end
    // No pull-up: outside reads the line toggles
    always @(negedge sclk or posedge csN) begin
        if (!csN && rdLeft > 0) begin
            devDataOut = word[23];
            word = word << 1;
        end else devDataOut = ~devDataOut;
    end
endmodule : asrs_dev_model
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the sequencer: register bus master plus converter model.
// Assumes the designer's offsets and field layout for the control registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import asrs_pkg::*;
;
    logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, irq, sclk, csN, dIn, dOut, rdyN, clock_idle_polarity_select;
    int          fails, n_tests, cyc;
    asrs_sequencer uut (.mclk(mclk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq), .sclk(sclk), .csN(csN),
        .devDataIn(dIn), .devDataOut(dOut), .resultReadyN(rdyN), .clockIdlePolaritySelect(clock_idle_polarity_select));
    asrs_dev_model dev (.csN(csN), .sclk(sclk), .devDataIn(dIn), .devDataOut(dOut), .resultReadyN(rdyN));
    // ********************************************************
    // Bus tasks
    // ********************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    // One idle edge first, so back-to-back calls never set a strobe twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset;
        rd(OFS_CFG, v);
        chk("cfg", 32'h0020a04f, v);
        rd(OFS_COUNT, v);
        chk("count", 32'h3e8, v);
        rd(OFS_INTMASK, v);
        chk("mask", 32'h0, v);
        rd(8'h1c, v);
        chk("unmapped", 32'h2, {30'h0, resp});
        wr(8'h1c, 32'h0);
        chk("wr unmapped", 32'h2, {30'h0, resp});
        chk("polarity", 32'h1, {31'h0, clock_idle_polarity_select});
    endtask : t_reset
    // Whole run: setup bytes, then n guarded reads
    task automatic t_run(input logic [23:0] cfg, input int n, input logic [1:0] m);
        logic [7:0] e[$];
        e = '{8'h27, cfg[7:0], 8'h37, cfg[15:8], 8'h17, cfg[23:16]};
        repeat (n) e.push_back(8'h5f);
        dev.got.delete();
        wr(OFS_COUNT, n);
        wr(OFS_INTMASK, {30'h0, m});
        wr(OFS_CFG, {8'h0, cfg});
        wr(OFS_CTRL, 32'h1);
        do rd(OFS_STATUS, v); while (v[1] !== 1'b1);
        chk("taken", n, {16'h0, v[31:16]});
        chk("bytes", e.size(), dev.got.size());
        foreach (e[i]) chk("byte", e[i], dev.got[i]);
        chk("early", 0, dev.early);
        chk("fill", 0, dev.dirty);
        chk("irq", m != 0, irq);
        if (n > 0) begin
            rd(OFS_RESULT, v);
            chk("result", dev.sent, v);
        end
        rd(OFS_INTSTAT, v);
        chk("intstat", n > 0 ? 3 : 2, v);
        @(posedge mclk);
        chk("irq clear", 0, irq);
    endtask : t_run
    // ********************************************************
    // Clock, timeout, sequence
    // ********************************************************
    always #50 mclk = ~mclk;
    // Runs take a few thousand cycles; far above that means a hang
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        {mclk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {fails, n_tests, cyc} = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_run(24'h20a04f, 3, 2'h3);
        t_run(24'h115a8c, 0, 2'h0);
        t_run(24'h20a04f, 1, 2'h1);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
